// [design/mem_map_pkg.sv]
// Package with register map, field layouts, reset values and types of the memory map decoder
package mem_map_pkg;

    // ************************************************************
    // APB register byte offsets
    // ************************************************************
    localparam logic [7:0] ctrl_offset = 8'h00;
    localparam logic [7:0] data_wait_offset = 8'h04;
    localparam logic [7:0] io_wait_offset = 8'h08;
    localparam logic [7:0] status_offset = 8'h0C;
    localparam logic [7:0] mode_status_offset = 8'h10;

    // ************************************************************
    // Field layouts and reset values
    // ************************************************************
    localparam int ctrl_pm_ovl_lsb = 0;
    localparam int ctrl_dm_ovl_lsb = 2;
    localparam int ovl_width = 2;
    localparam int wait_width = 3;
    localparam int io_regions = 4;
    localparam logic [1:0] ovl_reset = 2'h0;
    localparam logic [2:0] wait_reset = 3'h0;
    localparam logic [15:0] mode_status_reset = 16'h0000;
    localparam logic [7:0] stack_ptr_empty = 8'h00;
    localparam logic [15:0] imask_all_masked = 16'h0000;

    // ************************************************************
    // Address map
    // ************************************************************
    localparam logic [13:0] pm_upper_base = 14'h2000;
    localparam logic [13:0] dm_regs_base = 14'h3FE0;
    localparam logic [13:0] dm_lower_top = 14'h1FFF;
    localparam logic [13:0] first_fetch_addr = 14'h0000;
    localparam int io_region_msb = 10;
    localparam int io_region_lsb = 9;
    localparam logic [1:0] ovl_seg1 = 2'h1;
    localparam logic [1:0] ovl_seg2 = 2'h2;

    // ************************************************************
    // Reset and boot timing
    // ************************************************************
    localparam int clk_period_ns = 100;
    localparam int pll_lock_cycles = 2000;
    localparam int boot_words = 32;
    localparam int boot_cycles_per_word = 3;
    localparam logic [7:0] boot_cycles = 8'(boot_words * boot_cycles_per_word);

    typedef enum logic [1:0] {
        seq_reset,
        seq_boot,
        seq_run
    } seq_state_t;

    typedef struct packed {
        logic [13:0] addr;
        logic req;
        logic write;
    } mem_req_t;

    typedef struct packed {
        logic [13:0] addr;
        logic ext;
        logic regs;
        logic [2:0] wait_count;
    } route_t;

endpackage

// [design/memory_map_overlay_decoder.sv]
// Memory map overlay decoder: program, data, I/O and byte space decode with APB registers
//
// The address map and the APB slave port were chosen for this implementation.
`timescale 1ns/100ps

module memory_map_overlay_decoder (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    // Straps and bus arbitration
    input wire logic memory_map_select_in,
    input wire logic bus_request_in,
    // APB slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Core access requests
    input wire mem_map_pkg::mem_req_t pm_fetch_in,
    input wire mem_map_pkg::mem_req_t pm_data_in,
    input wire mem_map_pkg::mem_req_t dm_in,
    input wire mem_map_pkg::mem_req_t io_in,
    input wire logic [21:0] byte_addr_in,
    input wire logic byte_req_in,
    input wire logic [7:0] byte_data_in,
    // Decode results
    output mem_map_pkg::route_t pm_fetch_route_out,
    output mem_map_pkg::route_t pm_data_route_out,
    output mem_map_pkg::route_t dm_route_out,
    output logic [13:0] ext_addr_out,
    output logic [23:0] ext_data_out,
    output logic ext_data_oe_out,
    output logic core_stall_out,
    // Sequencer and processor state
    output logic core_run_out,
    output logic boot_active_out,
    output logic [13:0] first_fetch_addr_out,
    output logic [15:0] processor_mode_status_out,
    output logic [15:0] imask_out,
    output logic [7:0] stack_ptr_out
);

    typedef struct packed {
        mem_map_pkg::seq_state_t seq;
        logic [7:0] boot_cnt;
        logic boot_enable;
        logic [1:0] program_overlay_select;
        logic [1:0] data_overlay_select;
        logic [2:0] data_external_wait_count;
        logic [11:0] io_wait;
        logic [2:0] wait_cnt;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        mem_map_pkg::route_t pmf;
        mem_map_pkg::route_t pmd;
        mem_map_pkg::route_t dmr;
        logic [13:0] ext_addr;
        logic [23:0] ext_data;
        logic ext_oe;
        logic stall;
        logic [15:0] mode_status;
        logic [15:0] imask;
        logic [7:0] stack_ptr;
    } state_t;

    state_t state_reg;
    state_t state_next;

    // ************************************************************
    // Program memory decode
    // ************************************************************
    function automatic mem_map_pkg::route_t pm_route(input mem_map_pkg::mem_req_t r, input logic map_hi,
                                                    input logic [1:0] ovl);
        mem_map_pkg::route_t o;
        o = '0;
        o.addr = r.addr;
        if (map_hi) begin
            o.ext = (r.addr < mem_map_pkg::pm_upper_base);
        end else if (ovl != mem_map_pkg::ovl_reset) begin
            o.ext = (r.addr >= mem_map_pkg::pm_upper_base);
            if (o.ext) begin
                o.addr = {ovl == mem_map_pkg::ovl_seg2, r.addr[12:0]};
            end
        end
        return o;
    endfunction

    logic [1:0] io_region;
    logic [2:0] io_wait_sel;
    logic apb_setup;
    logic dm_ext;
    mem_map_pkg::route_t dm_next;

    always_comb begin
        io_region = io_in.addr[mem_map_pkg::io_region_msb:mem_map_pkg::io_region_lsb];
        io_wait_sel = state_reg.io_wait[io_region * mem_map_pkg::wait_width +: mem_map_pkg::wait_width];
        apb_setup = psel_in && !penable_in;
        dm_ext = (state_reg.data_overlay_select != mem_map_pkg::ovl_reset)
                 && (dm_in.addr <= mem_map_pkg::dm_lower_top) && !memory_map_select_in;
        dm_next = '0;
        dm_next.addr = dm_in.addr;
        dm_next.ext = dm_ext;
        dm_next.regs = (dm_in.addr >= mem_map_pkg::dm_regs_base);
        if (dm_ext) begin
            dm_next.addr = {state_reg.data_overlay_select == mem_map_pkg::ovl_seg2, dm_in.addr[12:0]};
            dm_next.wait_count = state_reg.data_external_wait_count;
        end
    end

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        state_next = state_reg;
        state_next.pready = 1'b0;
        state_next.pslverr = 1'b0;
        // Both fetch and data port decode each cycle with the same program overlay select
        state_next.pmf = pm_route(pm_fetch_in, memory_map_select_in, state_reg.program_overlay_select);
        state_next.pmd = pm_route(pm_data_in, memory_map_select_in, state_reg.program_overlay_select);
        state_next.dmr = dm_next;
        state_next.ext_oe = 1'b0;
        state_next.stall = 1'b0;

        // Wait-state counter for external data and I/O accesses
        if (state_reg.wait_cnt != 3'h0) begin
            state_next.wait_cnt = state_reg.wait_cnt - 3'h1;
            state_next.stall = (state_reg.wait_cnt != 3'h1);
        end else if (io_in.req) begin
            state_next.ext_addr = {3'h0, io_in.addr[10:0]};
            state_next.wait_cnt = io_wait_sel;
            state_next.stall = (io_wait_sel != 3'h0);
            state_next.ext_oe = io_in.write;
        end else if (dm_in.req && dm_ext) begin
            state_next.ext_addr = dm_next.addr;
            state_next.wait_cnt = state_reg.data_external_wait_count;
            state_next.stall = (state_reg.data_external_wait_count != 3'h0);
            state_next.ext_oe = dm_in.write;
        end else if (byte_req_in) begin
            state_next.ext_addr = byte_addr_in[13:0];
            state_next.ext_data = {byte_addr_in[21:14], byte_data_in, 8'h00};
            state_next.ext_oe = 1'b1;
        end else if (state_next.pmf.ext && pm_fetch_in.req) begin
            state_next.ext_addr = state_next.pmf.addr;
        end

        // Reset-release sequencing
        case (state_reg.seq)
            mem_map_pkg::seq_reset: begin
                if (!bus_request_in) begin
                    state_next.boot_enable = !memory_map_select_in;
                    state_next.seq = memory_map_select_in ? mem_map_pkg::seq_run : mem_map_pkg::seq_boot;
                    state_next.boot_cnt = mem_map_pkg::boot_cycles;
                end
            end
            mem_map_pkg::seq_boot: begin
                state_next.boot_cnt = state_reg.boot_cnt - 8'h01;
                if (state_reg.boot_cnt == 8'h01) begin
                    state_next.seq = mem_map_pkg::seq_run;
                end
            end
            mem_map_pkg::seq_run: begin
                state_next.seq = mem_map_pkg::seq_run;
            end
            default: begin
                state_next.seq = mem_map_pkg::seq_reset;
            end
        endcase

        // APB register access, answered in the access phase with no wait
        if (apb_setup) begin
            state_next.prdata = 32'h0000_0000;
            case (paddr_in)
                mem_map_pkg::ctrl_offset: begin
                    state_next.prdata = {28'h000_0000, state_reg.data_overlay_select,
                                         state_reg.program_overlay_select};
                end
                mem_map_pkg::data_wait_offset: begin
                    state_next.prdata = {29'h0000_0000, state_reg.data_external_wait_count};
                end
                mem_map_pkg::io_wait_offset: begin
                    state_next.prdata = {20'h0_0000, state_reg.io_wait};
                end
                mem_map_pkg::status_offset: begin
                    state_next.prdata = {28'h000_0000, state_reg.boot_enable, state_reg.stall,
                                         state_reg.seq == mem_map_pkg::seq_run,
                                         state_reg.seq == mem_map_pkg::seq_boot};
                end
                mem_map_pkg::mode_status_offset: begin
                    state_next.prdata = {16'h0000, state_reg.mode_status};
                end
                default: begin
                    state_next.pslverr = 1'b1;
                end
            endcase
            state_next.pready = 1'b1;
        end

        // Writes land at the access edge where the master samples pready high
        if (psel_in && penable_in && state_reg.pready && pwrite_in) begin
            case (paddr_in)
                mem_map_pkg::ctrl_offset: begin
                    // Map select high forces the program overlay off
                    state_next.program_overlay_select = memory_map_select_in ? mem_map_pkg::ovl_reset
                        : pwdata_in[mem_map_pkg::ctrl_pm_ovl_lsb +: mem_map_pkg::ovl_width];
                    state_next.data_overlay_select =
                        pwdata_in[mem_map_pkg::ctrl_dm_ovl_lsb +: mem_map_pkg::ovl_width];
                end
                mem_map_pkg::data_wait_offset: begin
                    state_next.data_external_wait_count = pwdata_in[2:0];
                end
                mem_map_pkg::io_wait_offset: begin
                    state_next.io_wait = pwdata_in[11:0];
                end
                mem_map_pkg::mode_status_offset: begin
                    state_next.mode_status = pwdata_in[15:0];
                end
                default: begin
                end
            endcase
        end

        // Master reset; the clock keeps running so no settle delay follows
        if (!nrst_in) begin
            state_next = '0;
            state_next.seq = mem_map_pkg::seq_reset;
            state_next.stack_ptr = mem_map_pkg::stack_ptr_empty;
            state_next.imask = mem_map_pkg::imask_all_masked;
            state_next.mode_status = mem_map_pkg::mode_status_reset;
            state_next.program_overlay_select = mem_map_pkg::ovl_reset;
            state_next.data_overlay_select = mem_map_pkg::ovl_reset;
            state_next.data_external_wait_count = mem_map_pkg::wait_reset;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        state_reg <= state_next;
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign prdata_out = state_reg.prdata;
    assign pready_out = state_reg.pready;
    assign pslverr_out = state_reg.pslverr;
    assign pm_fetch_route_out = state_reg.pmf;
    assign pm_data_route_out = state_reg.pmd;
    assign dm_route_out = state_reg.dmr;
    assign ext_addr_out = state_reg.ext_addr;
    assign ext_data_out = state_reg.ext_data;
    assign ext_data_oe_out = state_reg.ext_oe;
    assign core_stall_out = state_reg.stall;
    assign core_run_out = (state_reg.seq == mem_map_pkg::seq_run);
    assign boot_active_out = (state_reg.seq == mem_map_pkg::seq_boot);
    // Sequencer start address is fixed; overlay state is not part of it
    assign first_fetch_addr_out = mem_map_pkg::first_fetch_addr;
    assign processor_mode_status_out = state_reg.mode_status;
    assign imask_out = state_reg.imask;
    assign stack_ptr_out = state_reg.stack_ptr;

endmodule

// [sim/memory_map_overlay_decoder_tb_top.sv]
// Self-checking bench of the memory map overlay decoder
`timescale 1ns/100ps

module memory_map_overlay_decoder_tb_top;
    logic ref_clk_in, nrst_in, memory_map_select_in, bus_request_in, psel_in, penable_in, pwrite_in, byte_req_in;
    logic [7:0] paddr_in, byte_data_in, stack_ptr_out, seen_data;
    logic [31:0] pwdata_in, prdata_out, rd;
    logic pready_out, pslverr_out, ext_data_oe_out, core_stall_out, core_run_out, boot_active_out, err;
    logic [21:0] byte_addr_in, seen_addr;
    logic [13:0] ext_addr_out, first_fetch_addr_out;
    logic [23:0] ext_data_out;
    logic [15:0] processor_mode_status_out, imask_out;
    mem_map_pkg::mem_req_t pm_fetch_in, pm_data_in, dm_in, io_in;
    mem_map_pkg::route_t pm_fetch_route_out, pm_data_route_out, dm_route_out;
    int num_errors = 0;
    int n_tests = 0;
    int n;

    memory_map_overlay_decoder memory_map_overlay_decoder_inst (.*);
    mm_ext_mem mm_ext_mem_inst (.ref_clk_in(ref_clk_in), .addr_in(ext_addr_out), .data_in(ext_data_out),
        .oe_in(ext_data_oe_out), .seen_addr_out(seen_addr), .seen_data_out(seen_data));

    initial begin
        ref_clk_in = 0;
        forever #50 ref_clk_in = ~ref_clk_in;
    end

    task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic summarize;
        if (num_errors == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // APB transfer held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_in);
        psel_in <= 1;
        pwrite_in <= wr;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge ref_clk_in);
        penable_in <= 1;
        do begin
            @(posedge ref_clk_in);
        end while (pready_out !== 1'h1);
        rd = prdata_out;
        err = pslverr_out;
        psel_in <= 0;
        penable_in <= 0;
    endtask

    // One-cycle request, returns where its routes are readable
    task automatic pulse;
        @(posedge ref_clk_in);
        pm_fetch_in.req <= 0;
        pm_data_in.req <= 0;
        dm_in.req <= 0;
        io_in.req <= 0;
        byte_req_in <= 0;
        @(posedge ref_clk_in);
    endtask

    task automatic stalls;
        n = 0;
        for (int i = 0; i < 12 && core_stall_out === 1'h1; i++) begin
            n++;
            @(posedge ref_clk_in);
        end
    endtask

    task automatic do_reset(input logic m, input logic b);
        nrst_in <= 0;
        memory_map_select_in <= m;
        bus_request_in <= b;
        repeat (5) @(posedge ref_clk_in);
        nrst_in <= 1;
        repeat (2) @(posedge ref_clk_in);
    endtask

    initial begin
        repeat (20000) @(posedge ref_clk_in);
        num_errors++;
        summarize();
    end

    initial begin
        {nrst_in, memory_map_select_in, psel_in, penable_in, pwrite_in, byte_req_in} = '0;
        bus_request_in = 1;
        {paddr_in, pwdata_in, byte_addr_in, byte_data_in} = '0;
        {pm_fetch_in, pm_data_in, dm_in, io_in} = '0;
        do_reset(1'h0, 1'h1);
        check("held", {core_run_out, boot_active_out}, 0);
        check("mode", processor_mode_status_out, 0);
        check("imask", imask_out, 0);
        check("stack", stack_ptr_out, 0);
        bus_request_in <= 0;
        repeat (2) @(posedge ref_clk_in);
        check("boot", boot_active_out, 1);
        for (int i = 0; i < 300 && core_run_out !== 1'h1; i++) @(posedge ref_clk_in);
        check("first", {core_run_out, boot_active_out, first_fetch_addr_out}, 32'h0000_8000);
        for (int a = 0; a <= 16; a += 4) begin
            apb(1'h0, 8'(a), 32'h0000_0000);
            if (a != 12) check("reset reg", rd, 0);
        end
        apb(1'h0, 8'h20, 32'h0000_0000);
        check("unmapped err", err, 1);
        check("unmapped rd", rd, 0);
        for (int ov = 0; ov < 3; ov++) begin
            apb(1'h1, mem_map_pkg::ctrl_offset, 32'(ov));
            pm_fetch_in <= '{14'h2ABC, 1'h1, 1'h0};
            pm_data_in <= '{14'h3123, 1'h1, 1'h0};
            pulse();
            check("pm ext", {pm_fetch_route_out.ext, pm_data_route_out.ext}, ov != 0 ? 3 : 0);
            if (ov != 0) check("pm addr", pm_fetch_route_out.addr, {ov == 2, 13'h0ABC});
            if (ov != 0) check("pmd addr", pm_data_route_out.addr, {ov == 2, 13'h1123});
        end
        apb(1'h1, mem_map_pkg::data_wait_offset, 32'h0000_0003);
        for (int ov = 0; ov < 3; ov++) begin
            apb(1'h1, mem_map_pkg::ctrl_offset, 32'(ov << 2));
            dm_in <= '{14'h0005, 1'h1, 1'h0};
            pulse();
            check("dm ext", dm_route_out.ext, ov != 0);
            if (ov != 0) check("dm addr", ext_addr_out, {ov == 2, 13'h0005});
            stalls();
            check("dm waits", n, ov != 0 ? 3 : 0);
        end
        for (int k = 0; k < 2; k++) begin
            dm_in <= '{14'h3FDF + 14'(k), 1'h1, 1'h0};
            pulse();
            check("dm regs", {dm_route_out.regs, dm_route_out.ext, core_stall_out}, {k[0], 2'h0});
        end
        apb(1'h1, mem_map_pkg::io_wait_offset, 32'h0000_0F08);
        for (int r = 0; r < 4; r++) begin
            io_in <= '{{3'h7, 2'(r), 9'h1FF}, 1'h1, 1'h0};
            pulse();
            check("io addr", ext_addr_out[10:0], {2'(r), 9'h1FF});
            stalls();
            check("io waits", n, (32'h0000_0F08 >> (3 * r)) & 7);
        end
        byte_addr_in <= 22'h25_1A3C;
        byte_data_in <= 8'hC3;
        byte_req_in <= 1;
        pm_fetch_in <= '{14'h0010, 1'h1, 1'h0};
        pulse();
        check("byte oe", ext_data_oe_out, 1);
        @(posedge ref_clk_in);
        check("byte addr", seen_addr, 22'h25_1A3C);
        check("byte data", seen_data, 8'hC3);
        do_reset(1'h1, 1'h0);
        check("compat", {core_run_out, boot_active_out}, 2);
        apb(1'h1, mem_map_pkg::ctrl_offset, 32'h0000_0008);
        apb(1'h0, mem_map_pkg::ctrl_offset, 32'h0000_0000);
        check("pm ovl", rd[1:0], 0);
        pm_fetch_in <= '{14'h0100, 1'h1, 1'h0};
        dm_in <= '{14'h0005, 1'h1, 1'h0};
        pulse();
        check("low pm", {pm_fetch_route_out.ext, pm_fetch_route_out.addr}, 15'h4100);
        check("dm ovl", dm_route_out.ext, 0);
        pm_fetch_in <= '{14'h2100, 1'h1, 1'h0};
        pulse();
        check("high pm", pm_fetch_route_out.ext, 0);
        do_reset(1'h0, 1'h0);
        check("reboot", boot_active_out, 1);
        summarize();
    end
endmodule

// [sim/mm_chk.sv]
// Checker of decode and sequencing behaviour at the decoder ports
`timescale 1ns/100ps

module mm_chk (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    // Inputs
    input wire logic memory_map_select_in,
    input wire logic bus_request_in,
    input wire mem_map_pkg::mem_req_t pm_fetch_in,
    input wire mem_map_pkg::mem_req_t dm_in,
    input wire mem_map_pkg::mem_req_t io_in,
    input wire logic [21:0] byte_addr_in,
    input wire logic byte_req_in,
    input wire logic [7:0] byte_data_in,
    // Outputs
    input wire mem_map_pkg::route_t pm_fetch_route_out,
    input wire mem_map_pkg::route_t dm_route_out,
    input wire logic [13:0] ext_addr_out,
    input wire logic [23:0] ext_data_out,
    input wire logic core_run_out,
    input wire logic boot_active_out,
    input wire logic [15:0] processor_mode_status_out,
    input wire logic [15:0] imask_out,
    input wire logic [7:0] stack_ptr_out
);
    default clocking @(posedge ref_clk_in);
    endclocking
    default disable iff (!nrst_in);

    property p_clr; $rose(nrst_in) |-> {processor_mode_status_out, imask_out, stack_ptr_out} == 40'h00_0000_0000; endproperty
    a_clr: assert property (p_clr) else $error("state not cleared");
    property p_boot; $rose(nrst_in) && !memory_map_select_in && !bus_request_in |=> boot_active_out; endproperty
    a_boot: assert property (p_boot) else $error("boot not entered");
    property p_compat; $rose(nrst_in) && memory_map_select_in && !bus_request_in |=> core_run_out && !boot_active_out; endproperty
    a_compat: assert property (p_compat) else $error("compat start wrong");
    property p_run; $fell(boot_active_out) |-> core_run_out; endproperty
    a_run: assert property (p_run) else $error("no run after boot");
    property p_pm_low; pm_fetch_in.req && !pm_fetch_in.addr[13] && !memory_map_select_in |=> !pm_fetch_route_out.ext; endproperty
    a_pm_low: assert property (p_pm_low) else $error("pm lower half external");
    property p_dm_high; dm_in.req && dm_in.addr[13] |=> !dm_route_out.ext; endproperty
    a_dm_high: assert property (p_dm_high) else $error("dm upper half external");
    property p_regs; dm_in.req && dm_in.addr >= 14'h3FE0 |=> dm_route_out.regs; endproperty
    a_regs: assert property (p_regs) else $error("register window missed");
    property p_io; io_in.req |=> ext_addr_out[10:0] == $past(io_in.addr[10:0]); endproperty
    a_io: assert property (p_io) else $error("io address wrong");
    property p_byte;
        byte_req_in && !io_in.req && !dm_in.req |=>
            {ext_data_out[23:8], ext_addr_out} == $past({byte_addr_in[21:14], byte_data_in, byte_addr_in[13:0]});
    endproperty
    a_byte: assert property (p_byte) else $error("byte address wrong");
    c_boot: cover property ($fell(boot_active_out));
    c_dm_ext: cover property (dm_route_out.ext);
    c_io: cover property (io_in.req);
endmodule

bind memory_map_overlay_decoder mm_chk mm_chk_inst (.*);

// [sim/mm_ext_mem.sv]
// External byte memory stand-in that keeps the last access driven to it with oe_in high
`timescale 1ns/100ps

module mm_ext_mem (
    // Clock
    input wire logic ref_clk_in,
    // External bus
    input wire logic [13:0] addr_in,
    input wire logic [23:0] data_in,
    input wire logic oe_in,
    // Last access seen with oe_in high
    output logic [21:0] seen_addr_out,
    output logic [7:0] seen_data_out
);
    always_ff @(posedge ref_clk_in) begin
        if (oe_in) begin
            seen_addr_out <= {data_in[23:16], addr_in};
            seen_data_out <= data_in[15:8];
        end
    end
endmodule
